// ### inc/dschp_pkg.sv
// Constants shared by the dual serial controller host port and its modem-line channel logic.
// Assumes one 250 MHz system clock and an asynchronous active-low reset.
package dschp_pkg;
  localparam int DSCHP_CHANS = 2;
  localparam int DSCHP_DW = 8;
  // Synchronised pin bundle positions
  localparam int PIN_CHAN_B = 13;
  localparam int PIN_CTRL = 12;
  localparam int PIN_CE_N = 11;
  localparam int PIN_RD_N = 10;
  localparam int PIN_IO_REQUEST_N_N = 9;
  localparam int PIN_M1_N = 8;
  localparam int PIN_W = 14;
  // Command byte fields
  localparam int CMD_IE_BIT = 0;
  localparam int CMD_CLR_BIT = 4;
  localparam int CMD_AUTO_BIT = 5;
  // Status byte fields
  localparam int ST_PEND_BIT = 1;
  localparam int ST_DCD_BIT = 3;
  localparam int ST_CTS_BIT = 5;
  // Reset values
  localparam logic RST_MARK = 1'b1;
  localparam logic RST_MODEM_N = 1'b1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Arbitrary vector value
  localparam logic [7:0] DEF_VECTOR = 8'h5a;
endpackage

// ### inc/dschp_chan_if.sv
// Bundle between the host port and one channel's modem-line logic.
// Assumes both ends on sys_clk.
`timescale 1ns/10ps
interface dschp_chan_if;
  logic auto_en;
  logic ext_ie;
  logic clr_pend;
  logic cts;
  logic dcd;
  logic pend;
  logic tx_en;
  logic rx_en;
  modport port (output auto_en, output ext_ie, output clr_pend,
                input cts, input dcd, input pend, input tx_en, input rx_en);
  modport chan (input auto_en, input ext_ie, input clr_pend,
                output cts, output dcd, output pend, output tx_en, output rx_en);
endinterface

// ### hw/dschp_modem_chan.sv
// Modem-line logic of one channel: clear-to-send and carrier-detect handling.
// Assumes raw pins from outside sys_clk; configuration from the host port.
`timescale 1ns/10ps
module dschp_modem_chan
  import dschp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic send_permit_n,
  input wire logic carrier_detect_n,
  dschp_chan_if.chan ci
);
  typedef struct packed {
    logic cts_s1;
    logic cts_s2;
    logic dcd_s1;
    logic dcd_s2;
    logic cts_prev;
    logic cts;
    logic dcd;
    logic pend;
    logic tx_en;
    logic rx_en;
  } dschp_mc_s;

  dschp_mc_s st;
  dschp_mc_s next_st;

  always_comb begin
    next_st = st;
    next_st.cts_s1 = ~send_permit_n;
    next_st.cts_s2 = st.cts_s1;
    next_st.dcd_s1 = ~carrier_detect_n;
    next_st.dcd_s2 = st.dcd_s1;
    next_st.cts_prev = st.cts_s2;
    next_st.cts = st.cts_s2;
    next_st.dcd = st.dcd_s2;
    // Set wins over a clear in the same cycle
    if (ci.clr_pend) begin
      next_st.pend = 1'b0;
    end
    if (ci.ext_ie && (st.cts_s2 != st.cts_prev)) begin
      next_st.pend = 1'b1;
    end
    if (!ci.ext_ie) begin
      next_st.pend = 1'b0;
    end
    next_st.tx_en = ci.auto_en ? st.cts_s2 : 1'b1;
    next_st.rx_en = ci.auto_en ? st.dcd_s2 : 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ci.cts = st.cts;
  assign ci.dcd = st.dcd;
  assign ci.pend = st.pend;
  assign ci.tx_en = st.tx_en;
  assign ci.rx_en = st.rx_en;

  property p_auto_tx;
    @(posedge sys_clk) disable iff (!rst_n)
    (ci.auto_en && $past(ci.auto_en)) |-> (ci.tx_en == $past(st.cts_s2));
  endproperty
  a_auto_tx: assert property (p_auto_tx) else $error("tx enable not following send permit");

  property p_edge_pend;
    @(posedge sys_clk) disable iff (!rst_n)
    (ci.ext_ie && (st.cts_s2 != st.cts_prev)) |=> ci.pend;
  endproperty
  a_edge_pend: assert property (p_edge_pend) else $error("send permit edge did not raise pending");

  property p_pin_lat;
    @(posedge sys_clk) disable iff (!rst_n)
    $fell(send_permit_n) ##1 (!send_permit_n) [*3] |-> ci.cts;
  endproperty
  a_pin_lat: assert property (p_pin_lat) else $error("send permit level not visible after sync");
endmodule

// ### hw/dschp_host_port.sv
// Host-side bus port of a dual-channel serial controller.
// Assumes bus pins asynchronous to sys_clk; serial engines sit outside.
//
// What this block does
// - Channel select high picks B, low A
// - Write with control select high is command
// - Act on reads and writes only while chip enable low; acknowledge cycles ignore it
// - Everything synchronous to one system clock
// - Auto enables: transmit only while permit low
// - Otherwise send permit readable as plain input
// - Interrupt on both send permit edges
// - Eight-bit three-state data bus, bit 0 LSB
// - Read needs enable, read, io request active
// - Acknowledge cycle drives vector if highest priority
// - Auto enables: carrier detect gates receiver
// - Reset idles channels, marks lines, kills interrupts
`timescale 1ns/10ps
module dschp_host_port
  import dschp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic chan_b_sel,
  input wire logic ctrl_sel,
  input wire logic chip_en_n,
  input wire logic read_n,
  input wire logic io_request_n,
  input wire logic opcode_fetch_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  input wire logic ie_in,
  output logic ie_out,
  output logic int_req_n,
  input wire logic send_permit_a_n,
  input wire logic send_permit_b_n,
  input wire logic carrier_detect_a_n,
  input wire logic carrier_detect_b_n,
  input wire logic [1:0] tx_bit,
  input wire logic [1:0] rts_req,
  input wire logic [7:0] rx_data_a,
  input wire logic [7:0] rx_data_b,
  input wire logic [7:0] vector,
  output logic serial_out_a,
  output logic serial_out_b,
  output logic request_send_a_n,
  output logic request_send_b_n,
  output logic [1:0] tx_enable,
  output logic [1:0] rx_enable,
  output logic wr_cmd,
  output logic wr_data,
  output logic rd_data,
  output logic wr_chan_b,
  output logic [7:0] wr_byte
);
  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic acc_prev;
    logic ack_prev;
    logic [1:0] auto_en;
    logic [1:0] ext_ie;
    logic [1:0] clr;
    logic [7:0] dout;
    logic oe_n;
    logic wr_cmd;
    logic wr_data;
    logic rd_data;
    logic wr_chan_b;
    logic [7:0] wr_byte;
    logic int_req_n;
    logic ie_out;
    logic serving;
    logic ser_a;
    logic ser_b;
    logic rts_a_n;
    logic rts_b_n;
  } dschp_hp_s;

  dschp_hp_s st;
  dschp_hp_s next_st;

  logic [1:0] cts;
  logic [1:0] dcd;
  logic [1:0] pend;
  logic [1:0] tx_en;
  logic [1:0] rx_en;
  logic [1:0] send_n;
  logic [1:0] carr_n;

  assign send_n = {send_permit_b_n, send_permit_a_n};
  assign carr_n = {carrier_detect_b_n, carrier_detect_a_n};

  // ----------------------------------------
  // Per-channel modem lines
  // ----------------------------------------
  for (genvar c = 0; c < DSCHP_CHANS; c++) begin : g_ch
    dschp_chan_if cif();
    assign cif.auto_en = st.auto_en[c];
    assign cif.ext_ie = st.ext_ie[c];
    assign cif.clr_pend = st.clr[c];
    assign cts[c] = cif.cts;
    assign dcd[c] = cif.dcd;
    assign pend[c] = cif.pend;
    assign tx_en[c] = cif.tx_en;
    assign rx_en[c] = cif.rx_en;
    dschp_modem_chan u_chan (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .send_permit_n(send_n[c]),
      .carrier_detect_n(carr_n[c]),
      .ci(cif.chan)
    );
  end

  function automatic logic [7:0] status_byte(input logic c, input logic d, input logic p);
    logic [7:0] b;
    b = RST_BYTE;
    b[ST_CTS_BIT] = c;
    b[ST_DCD_BIT] = d;
    b[ST_PEND_BIT] = p;
    return b;
  endfunction

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic acc;
  logic ack;
  logic chb;
  logic [7:0] din;
  always_comb begin
    // Two-stage synchronised pins only; s1 feeds nothing but s2
    acc = !st.s2[PIN_CE_N] && !st.s2[PIN_IO_REQUEST_N_N] && st.s2[PIN_M1_N];
    ack = !st.s2[PIN_IO_REQUEST_N_N] && !st.s2[PIN_M1_N];
    chb = st.s2[PIN_CHAN_B];
    din = st.s2[7:0];
  end

  always_comb begin
    next_st = st;
    next_st.s1 = {chan_b_sel, ctrl_sel, chip_en_n, read_n, io_request_n, opcode_fetch_n, data_in};
    next_st.s2 = st.s1;
    next_st.acc_prev = acc;
    next_st.ack_prev = ack;
    next_st.wr_cmd = 1'b0;
    next_st.wr_data = 1'b0;
    next_st.rd_data = 1'b0;
    next_st.clr = 2'b00;
    // Only the start of a strobe acts, so a long strobe is one access
    if (acc && !st.acc_prev) begin
      next_st.wr_chan_b = chb;
      if (!st.s2[PIN_RD_N]) begin
        next_st.oe_n = 1'b0;
        if (st.s2[PIN_CTRL]) begin
          next_st.dout = status_byte(cts[chb], dcd[chb], pend[chb]);
        end else begin
          next_st.dout = chb ? rx_data_b : rx_data_a;
          next_st.rd_data = 1'b1;
        end
      end else begin
        next_st.wr_byte = din;
        if (st.s2[PIN_CTRL]) begin
          next_st.wr_cmd = 1'b1;
          next_st.auto_en[chb] = din[CMD_AUTO_BIT];
          next_st.ext_ie[chb] = din[CMD_IE_BIT];
          next_st.clr[chb] = din[CMD_CLR_BIT];
          next_st.serving = st.serving && !din[CMD_CLR_BIT];
        end else begin
          next_st.wr_data = 1'b1;
        end
      end
    end
    // Acknowledge: only when upstream grants priority and this port asks
    if (ack && !st.ack_prev && st.s2[PIN_RD_N] && ie_in && !st.int_req_n) begin
      next_st.dout = vector;
      next_st.oe_n = 1'b0;
      next_st.serving = 1'b1;
    end
    if (!acc && !ack) begin
      next_st.oe_n = 1'b1;
    end
    // Pending being cleared this cycle must not re-request for one cycle
    next_st.int_req_n = !(|(pend & ~st.clr)) || st.serving;
    next_st.ie_out = ie_in && !st.serving;
    next_st.ser_a = tx_en[0] ? tx_bit[0] : RST_MARK;
    next_st.ser_b = tx_en[1] ? tx_bit[1] : RST_MARK;
    next_st.rts_a_n = !rts_req[0];
    next_st.rts_b_n = !rts_req[1];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      // Strobe stages start idle, so no false access edge follows reset
      st.s1[PIN_CE_N] <= 1'b1;
      st.s1[PIN_RD_N] <= 1'b1;
      st.s1[PIN_IO_REQUEST_N_N] <= 1'b1;
      st.s1[PIN_M1_N] <= 1'b1;
      st.s2[PIN_CE_N] <= 1'b1;
      st.s2[PIN_RD_N] <= 1'b1;
      st.s2[PIN_IO_REQUEST_N_N] <= 1'b1;
      st.s2[PIN_M1_N] <= 1'b1;
      st.oe_n <= 1'b1;
      st.int_req_n <= 1'b1;
      st.ser_a <= RST_MARK;
      st.ser_b <= RST_MARK;
      st.rts_a_n <= RST_MODEM_N;
      st.rts_b_n <= RST_MODEM_N;
    end else begin
      st <= next_st;
    end
  end

  assign data_out = st.dout;
  assign data_oe_n = st.oe_n;
  assign ie_out = st.ie_out;
  assign int_req_n = st.int_req_n;
  assign serial_out_a = st.ser_a;
  assign serial_out_b = st.ser_b;
  assign request_send_a_n = st.rts_a_n;
  assign request_send_b_n = st.rts_b_n;
  assign tx_enable = tx_en;
  assign rx_enable = rx_en;
  assign wr_cmd = st.wr_cmd;
  assign wr_data = st.wr_data;
  assign rd_data = st.rd_data;
  assign wr_chan_b = st.wr_chan_b;
  assign wr_byte = st.wr_byte;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_wr_start;
    acc && !st.acc_prev && st.s2[PIN_RD_N];
  endsequence

  property p_chan_sel;
    @(posedge sys_clk) disable iff (!rst_n)
    (acc && !st.acc_prev) |=> (wr_chan_b == $past(st.s2[PIN_CHAN_B]));
  endproperty
  a_chan_sel: assert property (p_chan_sel) else $error("wrong channel picked");

  property p_cmd_data;
    @(posedge sys_clk) disable iff (!rst_n)
    s_wr_start |=> (wr_cmd == $past(st.s2[PIN_CTRL])) && (wr_data != wr_cmd) && (wr_byte == $past(din));
  endproperty
  a_cmd_data: assert property (p_cmd_data) else $error("command and data write mixed up");

  property p_ce_gate;
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(wr_cmd || wr_data || rd_data) |-> !$past(st.s2[PIN_CE_N]);
  endproperty
  a_ce_gate: assert property (p_ce_gate) else $error("access without chip enable");

  property p_once;
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_cmd || wr_data) |=> !(wr_cmd || wr_data);
  endproperty
  a_once: assert property (p_once) else $error("one strobe decoded twice");

  property p_mark;
    @(posedge sys_clk) disable iff (!rst_n)
    !$past(tx_en[0]) |-> serial_out_a;
  endproperty
  a_mark: assert property (p_mark) else $error("serial out a not marking while disabled");

  property p_rd_drive;
    @(posedge sys_clk) disable iff (!rst_n)
    (acc && !st.acc_prev && !st.s2[PIN_RD_N]) |=> !data_oe_n ##1 (data_oe_n || $stable(data_out));
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("read did not drive bus");

  property p_vec;
    @(posedge sys_clk) disable iff (!rst_n)
    (ack && !st.ack_prev && st.s2[PIN_RD_N] && ie_in && !int_req_n) |=> (!data_oe_n && data_out == $past(vector));
  endproperty
  a_vec: assert property (p_vec) else $error("vector not driven on acknowledge");

  property p_int;
    @(posedge sys_clk) disable iff (!rst_n)
    (|(pend & ~st.clr) && !st.serving) |=> !int_req_n;
  endproperty
  a_int: assert property (p_int) else $error("pending edge did not request interrupt");
endmodule

// ### sim/dschp_host_model.sv
// Host processor model: runs I/O and acknowledge cycles on the port pins.
// Assumes the bench clock; the port answers reads through data_oe_n.
`timescale 1ns/10ps
module dschp_host_model (
  input wire logic sys_clk,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  output logic chan_b_sel,
  output logic ctrl_sel,
  output logic chip_en_n,
  output logic read_n,
  output logic io_request_n,
  output logic opcode_fetch_n,
  output logic [7:0] data_in
);
  logic [7:0] hd;
  logic hdrv;
  // Released bus shows inverted byte, so a stale value never matches
  assign data_in = !data_oe_n ? data_out : (hdrv ? hd : ~hd);
  initial begin
    chan_b_sel = 1'b0;
    ctrl_sel = 1'b0;
    chip_en_n = 1'b1;
    read_n = 1'b1;
    io_request_n = 1'b1;
    opcode_fetch_n = 1'b1;
    hd = 8'h00;
    hdrv = 1'b0;
  end
  // ----
  // Bus cycle
  // ----
  task automatic cyc(input logic rd, input logic m1, input logic ce, input logic b, input logic c,
                     input logic [7:0] d, output logic [7:0] q);
    int k;
    @(negedge sys_clk);
    chan_b_sel = b;
    ctrl_sel = c;
    chip_en_n = ce;
    read_n = rd;
    opcode_fetch_n = m1;
    io_request_n = 1'b0;
    hd = d;
    hdrv = rd & m1;
    k = 0;
    if (!rd || !m1) begin
      // Hold the request until the port drives the bus or 10 cycles pass
      while (data_oe_n !== 1'b0 && k < 10) begin
        @(negedge sys_clk);
        k++;
      end
    end else begin
      repeat (5) @(negedge sys_clk);
    end
    q = data_out;
    io_request_n = 1'b1;
    chip_en_n = 1'b1;
    read_n = 1'b1;
    opcode_fetch_n = 1'b1;
    hdrv = 1'b0;
    // Gap lets the synchronised strobe drop before the next cycle
    repeat (5) @(negedge sys_clk);
  endtask
endmodule

// ### sim/tb.sv
// Self-checking bench of the dual serial controller host port.
// Assumes the host model drives the bus; modem pins come from here.
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; $display("ERROR %0t mismatch", $time); end end
module tb;
  import dschp_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic chan_b_sel, ctrl_sel, chip_en_n, read_n, io_request_n, opcode_fetch_n;
  logic [7:0] data_in, data_out, wr_byte;
  logic data_oe_n, ie_out, int_req_n, serial_out_a, serial_out_b;
  logic request_send_a_n, request_send_b_n, wr_cmd, wr_data, rd_data, wr_chan_b;
  logic [1:0] tx_enable, rx_enable;
  logic pa_n = 1'b0;
  logic pb_n = 1'b0;
  logic da_n = 1'b1;
  logic ie_in = 1'b1;
  logic [1:0] tx_bit = 2'b00;
  logic [7:0] q;
  int err_count = 0;
  int cmp_count = 0;
  int n_cmd = 0;
  int n_dat = 0;
  int n_rd = 0;
  int cyc_n = 0;
  always #2 sys_clk = ~sys_clk;
  dschp_host_model dschp_host_model_inst (.sys_clk(sys_clk), .data_out(data_out), .data_oe_n(data_oe_n),
    .chan_b_sel(chan_b_sel), .ctrl_sel(ctrl_sel), .chip_en_n(chip_en_n), .read_n(read_n),
    .io_request_n(io_request_n), .opcode_fetch_n(opcode_fetch_n), .data_in(data_in));
  dschp_host_port dschp_host_port_inst (.sys_clk(sys_clk), .rst_n(rst_n), .chan_b_sel(chan_b_sel),
    .ctrl_sel(ctrl_sel), .chip_en_n(chip_en_n), .read_n(read_n), .io_request_n(io_request_n),
    .opcode_fetch_n(opcode_fetch_n), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .ie_in(ie_in), .ie_out(ie_out), .int_req_n(int_req_n), .send_permit_a_n(pa_n), .send_permit_b_n(pb_n),
    .carrier_detect_a_n(da_n), .carrier_detect_b_n(1'b1), .tx_bit(tx_bit), .rts_req(2'b11),
    .rx_data_a(8'h3c), .rx_data_b(8'h96), .vector(8'hc3), .serial_out_a(serial_out_a),
    .serial_out_b(serial_out_b), .request_send_a_n(request_send_a_n), .request_send_b_n(request_send_b_n),
    .tx_enable(tx_enable), .rx_enable(rx_enable), .wr_cmd(wr_cmd), .wr_data(wr_data), .rd_data(rd_data),
    .wr_chan_b(wr_chan_b), .wr_byte(wr_byte));
  // Pulses counted on the falling edge, away from the rising launching edge
  always @(negedge sys_clk) begin
    n_cmd += (wr_cmd === 1'b1);
    n_dat += (wr_data === 1'b1);
    n_rd += (rd_data === 1'b1);
  end
  // ----
  // Closing and hang guard
  // ----
  task automatic stop_test;
    if (err_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic wr(input logic b, input logic c, input logic [7:0] d);
    dschp_host_model_inst.cyc(1'b1, 1'b1, 1'b0, b, c, d, q);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    repeat (10) @(negedge sys_clk);
    `CHK({data_oe_n, int_req_n, serial_out_a, serial_out_b}, 4'hf)
    `CHK({request_send_a_n, request_send_b_n, tx_enable, rx_enable}, 6'h30)
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    `CHK({request_send_a_n, request_send_b_n}, 2'b00)
  endtask
  task automatic t_write;
    wr(1'b0, 1'b1, 8'h40);
    `CHK(n_cmd, 1)
    `CHK({wr_chan_b, wr_byte}, 9'h040)
    wr(1'b1, 1'b0, 8'ha5);
    `CHK(n_dat, 1)
    `CHK({wr_chan_b, wr_byte}, 9'h1a5)
    dschp_host_model_inst.cyc(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 8'h21, q);
    `CHK(n_cmd + n_dat, 2)
    `CHK(wr_byte, 8'ha5)
  endtask
  task automatic t_read;
    dschp_host_model_inst.cyc(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 8'h00, q);
    `CHK(q, 8'h20)
    dschp_host_model_inst.cyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 8'h00, q);
    `CHK(q, 8'h96)
    `CHK(n_rd, 1)
    dschp_host_model_inst.cyc(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 8'h00, q);
    `CHK({n_rd, data_oe_n}, {32'sd1, 1'b1})
    dschp_host_model_inst.cyc(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00, q);
    `CHK(q, 8'h3c)
    `CHK(n_rd, 2)
  endtask
  task automatic t_auto;
    wr(1'b0, 1'b1, 8'h20);
    pa_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    `CHK({tx_enable, rx_enable}, 4'ha)
    `CHK(serial_out_a, RST_MARK)
    `CHK(serial_out_b, 1'b0)
    pa_n = 1'b0;
    da_n = 1'b0;
    tx_bit = 2'b10;
    repeat (8) @(negedge sys_clk);
    `CHK({tx_enable, rx_enable}, 4'hf)
    `CHK({serial_out_b, serial_out_a}, 2'b10)
    wr(1'b0, 1'b1, 8'h00);
  endtask
  task automatic t_int;
    wr(1'b0, 1'b1, 8'h01);
    `CHK(int_req_n, 1'b1)
    pa_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    `CHK({int_req_n, ie_out}, 2'b01)
    ie_in = 1'b0;
    dschp_host_model_inst.cyc(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00, q);
    `CHK(q == 8'hc3, 1'b0)
    `CHK({int_req_n, ie_out}, 2'b00)
    ie_in = 1'b1;
    dschp_host_model_inst.cyc(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00, q);
    `CHK(q, 8'hc3)
    `CHK({int_req_n, ie_out}, 2'b10)
    wr(1'b0, 1'b1, 8'h11);
    `CHK({int_req_n, ie_out}, 2'b11)
    pa_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    `CHK(int_req_n, 1'b0)
    wr(1'b0, 1'b1, 8'h00);
    `CHK(int_req_n, 1'b1)
  endtask
  task automatic t_rst_mid;
    wr(1'b0, 1'b1, 8'h01);
    pa_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    `CHK(int_req_n, 1'b0)
    rst_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    `CHK({int_req_n, ie_out, data_oe_n}, 3'b101)
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    pa_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    `CHK({int_req_n, ie_out}, 2'b11)
  endtask
  initial begin
    t_reset();
    t_write();
    t_read();
    t_auto();
    t_int();
    t_rst_mid();
    stop_test();
  end
endmodule
